//--- hdl/e1ram_pkg.sv
// Constants and types for the E1 receive alarm monitor
package e1ram_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  // ==========================================================================
  localparam logic [2:0] IDX_BLOCK_IRQ_ENABLE     = 3'h1;
  localparam logic [2:0] IDX_ALARM_ERROR_STATUS   = 3'h2;
  localparam logic [2:0] IDX_ALARM_ERROR_IRQ_EN   = 3'h3;
  localparam logic [2:0] IDX_IRQ_CONTROL          = 3'h4;
  localparam logic [2:0] IDX_STATUS_CLEAR         = 3'h5;
  localparam logic [2:0] IDX_ALARM_STATE          = 3'h6;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int BIT_BLOCK_ALARM_EN     = 1;
  localparam int BIT_REMOTE_CHANGE      = 0;
  localparam int BIT_LINE_CODE_VIOL     = 3;
  localparam int BIT_MF_REMOTE_CHANGE   = 5;
  localparam int BIT_RESET_UPON_READ    = 0;
  localparam int BIT_STATE_REMOTE       = 0;
  localparam int BIT_STATE_MF_REMOTE    = 1;
  localparam logic [7:0] STATUS_MASK    = 8'h29;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  RST_REG8      = 8'h00;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;
  localparam logic [6:0]  RST_COUNT     = 7'h00;
  localparam logic [16:0] RST_TIMER     = 17'h0_0000;

  // ==========================================================================
  // Timing and integration
  // ==========================================================================
  localparam int INTERVAL_US     = 4000;
  localparam int CLK_MHZ         = 20;
  localparam int INTERVAL_CYCLES = INTERVAL_US * CLK_MHZ;
  localparam logic [6:0] DECLARE_COUNT = 7'h50;

  // ==========================================================================
  // Bus handshake states
  // ==========================================================================
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } e1ram_bus_t;

endpackage : e1ram_pkg

//--- hdl/e1ram_top.sv
// E1 receive alarm monitor with Avalon-MM register slave
//
// Notes on behaviour
// - Block alarm enable bit 1 gates every alarm and error interrupt.
// - Remote alarm interrupt needs its own enable plus the block enable.
// - Status bit 0 sets on each remote alarm state change.
// - State-change flags stay set until the host clears them.
// - Reset-upon-read clears on read, otherwise only write-to-clear clears.
// - Stream split into 4 ms intervals; each marks multiframe pattern seen.
// - Valid intervals count up; multiframe alarm declared at 80.
// - Invalid intervals count down; multiframe alarm removed at zero.
// - Enable bit 5 gates the multiframe alarm change interrupt.
// - Status bit 5 sets on each multiframe alarm state change.
// - A mark with same polarity as the previous mark is a violation.
// - Violation interrupt needs its own enable plus the block enable.
// - Remote alarm integrates like the multiframe one: 4 ms, 80, zero.
// - Enable bit 0 gates the remote alarm change interrupt.
// - Enable bit 3 and status bit 3 serve line code violations.
module e1ram_top #(
  parameter int unsigned INTERVAL_CYCLES = e1ram_pkg::INTERVAL_CYCLES
) (
  input  wire logic        i_clk,               // 20 MHz clock
  input  wire logic        i_rst_n,             // Sync reset, active low
  input  wire logic        i_ce,                // Clock enable
  input  wire logic        i_bit_en,            // Line bit strobe
  input  wire logic        i_rx_pos,            // Positive mark
  input  wire logic        i_rx_neg,            // Negative mark
  input  wire logic        i_remote_pattern,    // Remote alarm pattern seen
  input  wire logic        i_mf_remote_pattern, // Multiframe pattern seen
  input  wire logic [7:0]  i_avs_address,       // Byte address
  input  wire logic        i_avs_read,          // Read request
  input  wire logic        i_avs_write,         // Write request
  input  wire logic [31:0] i_avs_writedata,     // Write data
  input  wire logic [3:0]  i_avs_byteenable,    // Byte enables
  output logic [31:0]      o_avs_readdata,      // Read data
  output logic             o_avs_waitrequest,   // Wait request
  output logic             o_irq,               // Level interrupt
  output logic             o_remote_alarm,      // Remote alarm declared
  output logic             o_mf_remote_alarm    // Multiframe alarm declared
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    e1ram_pkg::e1ram_bus_t bus;
    logic                  waitreq;
    logic [31:0]           rdata;
    logic [7:0]            block_irq_enable;
    logic [7:0]            alarm_error_status;
    logic [7:0]            alarm_error_irq_enable;
    logic [7:0]            irq_control;
    logic [16:0]           timer;
    logic [1:0]            seen;
    logic [1:0][6:0]       cnt;
    logic [1:0]            alarm;
    logic                  have_mark;
    logic                  last_pos;
    logic                  irq;
  } e1ram_state_t;

  localparam e1ram_state_t RESET_STATE = '{
    bus:                    e1ram_pkg::BUS_IDLE,
    waitreq:                1'b1,
    rdata:                  e1ram_pkg::RST_RDATA,
    block_irq_enable:       e1ram_pkg::RST_REG8,
    alarm_error_status:     e1ram_pkg::RST_REG8,
    alarm_error_irq_enable: e1ram_pkg::RST_REG8,
    irq_control:            e1ram_pkg::RST_REG8,
    timer:                  e1ram_pkg::RST_TIMER,
    seen:                   2'h0,
    cnt:                    {e1ram_pkg::RST_COUNT, e1ram_pkg::RST_COUNT},
    alarm:                  2'h0,
    have_mark:              1'b0,
    last_pos:               1'b0,
    irq:                    1'b0
  };

  localparam logic [16:0] TIMER_LAST = 17'(INTERVAL_CYCLES - 1);

  e1ram_state_t st;
  e1ram_state_t next_st;

  logic [1:0]  pattern;
  logic        interval_end;
  logic [6:0]  int_cnt_next [2];
  logic        int_alarm_next [2];
  logic [1:0]  alarm_changed;

  assign pattern      = {i_mf_remote_pattern, i_remote_pattern};
  assign interval_end = (st.timer == TIMER_LAST);

  // ==========================================================================
  // Alarm integrators: index 0 remote, index 1 multiframe
  // ==========================================================================
  for (genvar g = 0; g < 2; g++)
  begin : g_integ
    logic [6:0] cnt_n;
    logic       alarm_n;
    logic       valid;

    always_comb
    begin
      valid   = st.seen[g] | pattern[g];
      cnt_n   = st.cnt[g];
      alarm_n = st.alarm[g];
      if (interval_end)
      begin
        if (valid)
        begin
          if (st.cnt[g] != e1ram_pkg::DECLARE_COUNT)
            cnt_n = st.cnt[g] + 7'h01;
        end
        else if (st.cnt[g] != 7'h00)
        begin
          cnt_n = st.cnt[g] - 7'h01;
        end
        if (cnt_n == e1ram_pkg::DECLARE_COUNT)
          alarm_n = 1'b1;
        else if (cnt_n == 7'h00)
          alarm_n = 1'b0;
      end
    end

    assign int_cnt_next[g]   = cnt_n;
    assign int_alarm_next[g] = alarm_n;
    assign alarm_changed[g]  = alarm_n ^ st.alarm[g];
  end

  // ==========================================================================
  // Read data mux
  // ==========================================================================
  function automatic logic [31:0] read_mux(input e1ram_state_t s,
                                           input logic [2:0]   idx,
                                           input logic         hit);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (hit)
    begin
      case (idx)
        e1ram_pkg::IDX_BLOCK_IRQ_ENABLE:   d[7:0] = s.block_irq_enable;
        e1ram_pkg::IDX_ALARM_ERROR_STATUS: d[7:0] = s.alarm_error_status;
        e1ram_pkg::IDX_ALARM_ERROR_IRQ_EN: d[7:0] = s.alarm_error_irq_enable;
        e1ram_pkg::IDX_IRQ_CONTROL:        d[7:0] = s.irq_control;
        e1ram_pkg::IDX_ALARM_STATE:        d[1:0] = s.alarm;
        default:                           d      = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    logic [2:0] idx;
    logic       hit;
    logic       req;
    logic       wr_go;
    logic       rd_go;
    logic       mark;
    logic       violation;
    logic [7:0] set_bits;
    logic [7:0] clr_bits;
    logic [7:0] enabled;

    next_st   = st;
    idx       = i_avs_address[4:2];
    hit       = (i_avs_address[7:5] == 3'h0) && (i_avs_address[1:0] == 2'h0);
    req       = i_avs_read | i_avs_write;
    wr_go     = 1'b0;
    rd_go     = 1'b0;
    set_bits  = 8'h00;
    clr_bits  = 8'h00;
    mark      = 1'b0;
    violation = 1'b0;
    enabled   = 8'h00;

    // Avalon handshake: one wait cycle, then completion
    case (st.bus)
      e1ram_pkg::BUS_IDLE:
      begin
        if (req)
        begin
          next_st.bus     = e1ram_pkg::BUS_ACK;
          next_st.waitreq = 1'b0;
          next_st.rdata   = read_mux(st, idx, hit);
        end
      end
      e1ram_pkg::BUS_ACK:
      begin
        next_st.bus     = e1ram_pkg::BUS_IDLE;
        next_st.waitreq = 1'b1;
        wr_go           = i_avs_write & hit & i_avs_byteenable[0];
        rd_go           = i_avs_read & hit;
      end
      default:
      begin
        next_st.bus     = e1ram_pkg::BUS_IDLE;
        next_st.waitreq = 1'b1;
      end
    endcase

    if (wr_go)
    begin
      case (idx)
        e1ram_pkg::IDX_BLOCK_IRQ_ENABLE:
          next_st.block_irq_enable = i_avs_writedata[7:0];
        e1ram_pkg::IDX_ALARM_ERROR_IRQ_EN:
          next_st.alarm_error_irq_enable = i_avs_writedata[7:0];
        e1ram_pkg::IDX_IRQ_CONTROL:
          next_st.irq_control = i_avs_writedata[7:0];
        e1ram_pkg::IDX_STATUS_CLEAR:
          clr_bits = i_avs_writedata[7:0];
        default:
          clr_bits = 8'h00;
      endcase
    end

    // Only the bits actually returned are cleared on read
    if (rd_go && (idx == e1ram_pkg::IDX_ALARM_ERROR_STATUS) &&
        st.irq_control[e1ram_pkg::BIT_RESET_UPON_READ])
      clr_bits = st.rdata[7:0];

    // Interval timer and pattern capture
    if (interval_end)
    begin
      next_st.timer = 17'h0_0000;
      next_st.seen  = 2'h0;
    end
    else
    begin
      next_st.timer = st.timer + 17'h0_0001;
      next_st.seen  = st.seen | pattern;
    end
    next_st.cnt[0] = int_cnt_next[0];
    next_st.cnt[1] = int_cnt_next[1];
    next_st.alarm  = {int_alarm_next[1], int_alarm_next[0]};

    // Line code monitor
    mark      = i_bit_en & (i_rx_pos | i_rx_neg);
    violation = mark & st.have_mark & (i_rx_pos == st.last_pos);
    if (mark)
    begin
      next_st.have_mark = 1'b1;
      next_st.last_pos  = i_rx_pos;
    end

    set_bits[e1ram_pkg::BIT_REMOTE_CHANGE]    = alarm_changed[0];
    set_bits[e1ram_pkg::BIT_MF_REMOTE_CHANGE] = alarm_changed[1];
    set_bits[e1ram_pkg::BIT_LINE_CODE_VIOL]   = violation;

    // Sticky flags, a new event wins over a clear
    next_st.alarm_error_status =
      ((st.alarm_error_status & ~clr_bits) | set_bits) &
      e1ram_pkg::STATUS_MASK;

    enabled = next_st.alarm_error_status & next_st.alarm_error_irq_enable &
              e1ram_pkg::STATUS_MASK;
    next_st.irq = next_st.block_irq_enable[e1ram_pkg::BIT_BLOCK_ALARM_EN] &
                  (|enabled);
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      st <= RESET_STATE;
    else if (i_ce)
      st <= next_st;
  end

  assign o_avs_readdata    = st.rdata;
  assign o_avs_waitrequest = st.waitreq;
  assign o_irq             = st.irq;
  assign o_remote_alarm    = st.alarm[e1ram_pkg::BIT_STATE_REMOTE];
  assign o_mf_remote_alarm = st.alarm[e1ram_pkg::BIT_STATE_MF_REMOTE];

endmodule // e1ram_top

//--- bench/e1ram_assertions.sv
// Port-level checker for the E1 receive alarm monitor
module e1ram_assertions #(
  parameter int unsigned INTERVAL_CYCLES = e1ram_pkg::INTERVAL_CYCLES
) (
  input wire logic        i_clk,             // Clock
  input wire logic        i_rst_n,           // Reset
  input wire logic        i_ce,              // Clock enable
  input wire logic        i_rx_pos,          // Positive mark
  input wire logic        i_rx_neg,          // Negative mark
  input wire logic        i_bit_en,          // Strobe
  input wire logic [7:0]  i_avs_address,     // Address
  input wire logic        i_avs_read,        // Read
  input wire logic        i_avs_write,       // Write
  input wire logic [31:0] i_avs_writedata,   // Data
  input wire logic [3:0]  i_avs_byteenable,  // Lanes
  input wire logic [31:0] o_avs_readdata,    // Data
  input wire logic        o_avs_waitrequest, // Wait
  input wire logic        o_irq,             // Irq
  input wire logic        o_remote_alarm,    // Alarm
  input wire logic        o_mf_remote_alarm  // Alarm
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MIN_GAP = 80 * INTERVAL_CYCLES - 2;
  logic [31:0] gap_r;
  logic [31:0] gap_m;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================================================
  // Cycles since each alarm last moved
  // ==========================================================================
  always_ff @(posedge i_clk)
  begin
    gap_r <= (!i_rst_n || $changed(o_remote_alarm)) ? 32'h0000_0000 :
             gap_r + {31'h0000_0000, ~&gap_r};
    gap_m <= (!i_rst_n || $changed(o_mf_remote_alarm)) ? 32'h0000_0000 :
             gap_m + {31'h0000_0000, ~&gap_m};
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  AST_TAKE: assert property ((i_avs_read || i_avs_write) && i_ce &&
    o_avs_waitrequest |=> !o_avs_waitrequest) else $error("Late answer");
  AST_ONE_WAIT: assert property (!o_avs_waitrequest && i_ce |=>
    o_avs_waitrequest) else $error("Answer too long");
  AST_UNMAPPED: assert property (i_avs_read && o_avs_waitrequest && i_ce &&
    i_avs_address == 8'h1c |=> o_avs_readdata == 32'h0000_0000)
    else $error("Unmapped read not zero");
  AST_BLOCK_OFF: assert property (
    i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h04 && i_ce &&
    i_avs_byteenable[0] && !i_avs_writedata[1] |=> !o_irq [*3])
    else $error("Interrupt with block enable off");
  AST_IRQ_CAUSE: assert property (
    $rose(o_irq) |-> $past(i_avs_write) ||
    $past(i_bit_en && (i_rx_pos || i_rx_neg)) ||
    $changed(o_remote_alarm) || $changed(o_mf_remote_alarm))
    else $error("Interrupt without cause");
  AST_IRQ_FALL: assert property (
    $fell(o_irq) |-> !$past(o_avs_waitrequest))
    else $error("Interrupt dropped without access");
  AST_FREEZE: assert property (!i_ce |=> $stable(o_avs_waitrequest) &&
    $stable(o_avs_readdata) && $stable(o_irq) &&
    $stable(o_remote_alarm) && $stable(o_mf_remote_alarm))
    else $error("State moved with clock enable low");
  COV_FREEZE: cover property (!i_ce && (i_avs_read || i_avs_write));
  AST_REM_GAP: assert property (
    $changed(o_remote_alarm) |-> gap_r >= MIN_GAP)
    else $error("Remote alarm moved too soon");
  AST_MF_GAP: assert property (
    $changed(o_mf_remote_alarm) |-> gap_m >= MIN_GAP)
    else $error("Multiframe alarm moved too soon");
  COV_IRQ: cover property ($rose(o_irq));
  COV_MF: cover property ($rose(o_mf_remote_alarm));
  COV_REM_OFF: cover property ($fell(o_remote_alarm));
endmodule // e1ram_assertions

bind e1ram_top e1ram_assertions #(.INTERVAL_CYCLES(INTERVAL_CYCLES))
  e1ram_assertions_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_rx_pos(i_rx_pos), .i_rx_neg(i_rx_neg),
  .i_bit_en(i_bit_en), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_irq(o_irq), .o_remote_alarm(o_remote_alarm),
  .o_mf_remote_alarm(o_mf_remote_alarm));

//--- bench/e1ram_line_model.sv
// Line model: alternating marks, forced repeat, alarm patterns
module e1ram_line_model (
  input  wire logic i_clk,    // Clock
  input  wire logic i_rst_n,  // Reset, active low
  input  wire logic i_viol,   // Repeat next polarity
  input  wire logic i_rem,    // Remote pattern on
  input  wire logic i_mf,     // Multiframe pattern on
  output logic      o_bit_en, // Bit strobe
  output logic      o_pos,    // Positive mark
  output logic      o_neg,    // Negative mark
  output logic      o_rem,    // Remote pattern
  output logic      o_mf      // Multiframe pattern
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph;
  logic pol;
  logic rep;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ph <= 1'b0;
      pol <= 1'b0;
      rep <= 1'b0;
    end
    else
    begin
      ph <= ~ph;
      pol <= (ph && !rep) ? ~pol : pol;
      rep <= i_viol | (rep & ~ph);
    end
  end
  // Lines invert between strobes so stale values are never valid
  assign o_bit_en = ph;
  assign o_pos = ph ? pol : ~pol;
  assign o_neg = ph ? ~pol : pol;
  assign o_rem = i_rem & ph;
  assign o_mf = i_mf & ~ph;
endmodule // e1ram_line_model

//--- bench/e1_rx_alarm_monitor_tb.sv
// Self-checking bench for the E1 receive alarm monitor
module e1_rx_alarm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned IC = 8;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic viol = 1'b0, rem = 1'b0, mf = 1'b0, ce = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata, got;
  logic wreq, irq, ral, mal, ben, pos, neg, rp, mp;
  logic [15:0] seed = 16'h778d;
  logic [7:0] v;
  logic [7:0] amap [0:7] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                             8'h10, 8'h14, 8'h18, 8'h1c};
  int miscompares = 0, n_compared = 0, n;

  always #25 clk = ~clk;

  e1ram_top #(.INTERVAL_CYCLES(IC)) e1ram_top_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_bit_en(ben),
    .i_rx_pos(pos), .i_rx_neg(neg), .i_remote_pattern(rp),
    .i_mf_remote_pattern(mp), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .o_irq(irq),
    .o_remote_alarm(ral), .o_mf_remote_alarm(mal));
  e1ram_line_model e1ram_line_model_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_viol(viol), .i_rem(rem), .i_mf(mf),
    .o_bit_en(ben), .o_pos(pos), .o_neg(neg), .o_rem(rp), .o_mf(mp));

  function automatic logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction
  function automatic logic exp_irq(logic [7:0] blk, en, st);
    return blk[1] & (|(st & en & 8'h29));
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h00_0000, d};
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(got, {24'h00_0000, e});
  endtask
  task automatic irqchk(logic e);
    repeat (3) @(posedge clk);
    chk({31'h0000_0000, irq}, {31'h0000_0000, e});
  endtask
  task automatic inj();
    @(posedge clk);
    viol <= 1'b1;
    @(posedge clk);
    viol <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic alarm(int k, logic on);
    if (k) mf <= on;
    else rem <= on;
    n = 0;
    while ((k ? mal : ral) !== on && n < 90 * IC)
    begin
      @(posedge clk);
      n++;
    end
    chk(n >= 79 * IC && n <= 82 * IC, 32'h0000_0001);
    irqchk(k);
    rdchk(8'h08, k ? 8'h20 : 8'h01);
    rdchk(8'h18, on ? (k ? 8'h02 : 8'h01) : 8'h00);
    $display("Test alarm %0d to %0b done", k, on);
  endtask
  task automatic print_verdict();
    $display("Counts: %0d compared, %0d mismatched", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (amap[i]) rdchk(amap[i], 8'h00);
    repeat (3)
      foreach (amap[i])
      begin
        v = rnd();
        bus(1'b1, amap[i], v);
        rdchk(amap[i], (i == 1 || i == 3 || i == 4) ? v : 8'h00);
      end
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b1, 8'h0c, 8'h08);
    be <= 4'he;
    bus(1'b1, 8'h04, 8'hff);
    be <= 4'hf;
    rdchk(8'h04, 8'h00);
    // Freeze for four cycles: two marks skipped keeps polarity parity
    ce <= 1'b0;
    fork
      rdchk(8'h04, 8'h00);
      begin
        repeat (4) @(posedge clk);
        ce <= 1'b1;
      end
    join
    rdchk(8'h08, 8'h00);
    $display("Test registers done");
    inj();
    irqchk(exp_irq(8'h00, 8'h08, 8'h08));
    rdchk(8'h08, 8'h08);
    rdchk(8'h08, 8'h08);
    bus(1'b1, 8'h04, 8'h02);
    irqchk(exp_irq(8'h02, 8'h08, 8'h08));
    bus(1'b1, 8'h0c, 8'h00);
    irqchk(exp_irq(8'h02, 8'h00, 8'h08));
    bus(1'b1, 8'h0c, 8'h08);
    bus(1'b1, 8'h04, 8'h00);
    irqchk(exp_irq(8'h00, 8'h08, 8'h08));
    bus(1'b1, 8'h04, 8'h02);
    irqchk(exp_irq(8'h02, 8'h08, 8'h08));
    bus(1'b1, 8'h14, 8'h08);
    irqchk(1'b0);
    rdchk(8'h08, 8'h00);
    bus(1'b1, 8'h10, 8'h01);
    inj();
    irqchk(1'b1);
    rdchk(8'h08, 8'h08);
    irqchk(1'b0);
    rdchk(8'h08, 8'h00);
    $display("Test violation done");
    alarm(0, 1'b1);
    alarm(0, 1'b0);
    bus(1'b1, 8'h0c, 8'h20);
    alarm(1, 1'b1);
    alarm(1, 1'b0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(8'h04, 8'h00);
    irqchk(1'b0);
    $display("Test reset done");
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end
endmodule // e1_rx_alarm_monitor_tb
